// ==== common/ccptb_pkg.sv ====
// Register map, field layout and state types of the timer/compare/capture block
package ccptb_pkg;

  // Printed offsets (not all multiples of four): kept as indices, byte address = 4 * index
  localparam logic [11:0] IDX_TB_LOWER    = 12'h2A0;
  localparam logic [11:0] IDX_TB_UPPER    = 12'h2A2;
  localparam logic [11:0] IDX_PER_LOWER   = 12'h2A4;
  localparam logic [11:0] IDX_PER_UPPER   = 12'h2A6;
  localparam logic [11:0] IDX_PRI_CMP     = 12'h2A8;
  localparam logic [11:0] IDX_SEC_CMP     = 12'h2AC;
  localparam logic [11:0] IDX_CTRL_LOW    = 12'h2B4;
  localparam logic [11:0] IDX_CAP_LOWER   = 12'h2D4;
  localparam logic [11:0] IDX_CAP_UPPER   = 12'h2D6;
  localparam logic [11:0] IDX_STATUS      = 12'h29C;

  // Control field positions
  localparam int CTL_ENABLE    = 15;
  localparam int CTL_HALT_IDLE = 13;
  localparam int CTL_RUN_SLEEP = 12;
  localparam int CTL_RESYNC    = 11;
  localparam int CTL_SRC_HI    = 10;
  localparam int CTL_SRC_LO    = 8;
  localparam int CTL_PS_HI     = 7;
  localparam int CTL_PS_LO     = 6;
  localparam int CTL_WIDE      = 5;
  localparam int CTL_CAPSEL    = 4;
  localparam int CTL_FN_HI     = 3;
  localparam int CTL_FN_LO     = 0;
  localparam int STAT_AVAIL    = 0;
  localparam int STAT_OVF      = 1;

  // Count source encodings
  localparam logic [2:0] SRC_EXT_A   = 3'h7;
  localparam logic [2:0] SRC_EXT_B   = 3'h6;
  localparam logic [2:0] SRC_PLL     = 3'h5;
  localparam logic [2:0] SRC_PCLK2X  = 3'h4;
  localparam logic [2:0] SRC_LCELL   = 3'h3;
  localparam logic [2:0] SRC_SECONDARY_OSCILLATOR    = 3'h2;
  localparam logic [2:0] SRC_REFO    = 3'h1;
  localparam logic [2:0] SRC_PCLK    = 3'h0;

  // Prescale encodings and terminal counts (ratio minus one)
  localparam logic [1:0] PS_DIV64 = 2'h3;
  localparam logic [1:0] PS_DIV16 = 2'h2;
  localparam logic [1:0] PS_DIV4  = 2'h1;
  localparam logic [5:0] PS_TC64  = 6'h3F;
  localparam logic [5:0] PS_TC16  = 6'h0F;
  localparam logic [5:0] PS_TC4   = 6'h03;
  localparam logic [5:0] PS_TC1   = 6'h00;

  // Capture modes of the function field, then edge-count terminal values
  localparam logic [3:0] CAP_BOTH_ED  = 4'h0;
  localparam logic [3:0] CAP_RISE     = 4'h1;
  localparam logic [3:0] CAP_FALL     = 4'h2;
  localparam logic [3:0] CAP_BOTH     = 4'h3;
  localparam logic [3:0] CAP_RISE4    = 4'h4;
  localparam logic [3:0] CAP_RISE16   = 4'h5;
  localparam logic [3:0] EDGE_TC4     = 4'h3;
  localparam logic [3:0] EDGE_TC16    = 4'hF;

  localparam int          CAP_DEPTH   = 4;
  localparam logic [15:0] RST_HALF    = 16'h0000;
  localparam logic [1:0]  HTRANS_NSEQ = 2'h2;

  // Bus transaction phase
  typedef enum logic [0:0] {ccptb_idle, ccptb_data} ccptb_phase_t;

  // Clock candidates and power state, carried together
  typedef struct packed {
    logic ext_a;
    logic ext_b;
    logic pll;
    logic pclk2x;
    logic lcell;
    logic secondary_oscillator;
    logic refo;
    logic pclk;
  } ccptb_src_t;

  typedef struct packed {
    logic idle;
    logic sleep;
  } ccptb_pwr_t;

  // Whole state of the block
  typedef struct packed {
    ccptb_phase_t phase;
    logic [11:0]  idx;
    logic         wr;
    logic [15:0]  ctrl;
    logic [31:0]  tb;
    logic [31:0]  per;
    logic [15:0]  pri;
    logic [15:0]  sec;
    logic [127:0] fifo;
    logic [1:0]   rd_ptr;
    logic [2:0]   cnt;
    logic         ovf;
    logic [5:0]   ps;
    logic [3:0]   edges;
    logic [7:0]   s1;
    logic [7:0]   s2;
    logic [7:0]   s3;
    logic         cap1;
    logic         cap2;
    logic         cap3;
    logic         pri_hit;
    logic         sec_hit;
    logic         avail;
    logic [31:0]  rdata;
  } ccptb_state_t;

endpackage

// ==== core/ccptb_top.sv ====
// Time base, period, compare and capture FIFO unit behind an AHB-Lite slave
// Notes on behaviour
// - Upper count half is a read/write register
// - Lower period half, read/write, resets zero
// - Upper period half, read/write, resets zero
// - Primary compare value matched against count bits 15:0
// - Secondary compare value matched against count bits 15:0
// - Capture low returns oldest entry bits 15:0
// - Capture high returns oldest entry upper
// - Enable bit runs unit, else disabled
// - Halt-in-idle bit stops unit in Idle
// - Run-in-sleep bit keeps unit going asleep
// - Resync bit synchronises count source clock; the code synchronises the source whatever the bit holds
// - Three-bit field picks one of eight sources
// - Prescale divides by 1, 4, 16, 64
// - Wide select uses 32-bit count else 16
// - Capture path select picks capture or compare
// - Data-available flag follows FIFO non-empty
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
module ccptb_top
  import ccptb_pkg::*;
(
  // Clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // AHB-Lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  // Count sources and capture pin, asynchronous
  input  wire ccptb_pkg::ccptb_src_t  count_sources,
  input  wire logic                   capture_in,
  // Device power state
  input  wire ccptb_pkg::ccptb_pwr_t  power_state,
  // Compare and status outputs
  output logic                        primary_match,
  output logic                        secondary_match,
  output logic                        capture_data_available
);
  import ccptb_pkg::*;

  ccptb_state_t q, d;                 // Registered state and its next value
  logic         req;                  // Address phase accepted
  logic         run;                  // Unit counting this cycle
  logic         tick;                 // Rising edge of the selected source, prescaler input
  logic         src_now, src_old;     // Selected count source, now and last
  logic         rise, fall, cap_ev;   // Capture pin edges and event
  logic [31:0]  wide_tb;              // Count limited to the selected width
  logic [31:0]  wide_per;             // Period limited likewise
  logic [31:0]  wv;                   // Write data of the data phase
  logic [5:0]   ps_tc;                // Prescaler terminal count
  logic [1:0]   wr_ptr;               // FIFO write slot

  // Pick one synchronised source bit by select code
  function automatic logic pick_src(input logic [7:0] v, input logic [2:0] sel);
    pick_src = v[sel];
  endfunction

  assign req = hsel && hready && (htrans == HTRANS_NSEQ) && (hsize == 3'h2);

  // Outputs: ready and response tied off, the rest from flip-flops
  assign hreadyout              = 1'b1;
  assign hresp                  = 1'b0;
  assign hrdata                 = q.rdata;
  assign primary_match          = q.pri_hit;
  assign secondary_match        = q.sec_hit;
  assign capture_data_available = q.avail;

  // Combinational datapath and next state
  always_comb
  begin
    d   = q;
    wv  = hwdata;
    // Sources pass two flops; third stage only for edge detection
    d.s1 = count_sources;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.cap1 = capture_in;
    d.cap2 = q.cap1;
    d.cap3 = q.cap2;
    // Unit runs when enabled and the power state allows it
    run = q.ctrl[CTL_ENABLE]
          && !(power_state.idle && q.ctrl[CTL_HALT_IDLE])
          && !(power_state.sleep && !q.ctrl[CTL_RUN_SLEEP]);
    // Rising edge of the chosen source; resync off still samples, since one clock
    src_now = pick_src(q.s2, q.ctrl[CTL_SRC_HI:CTL_SRC_LO]);
    src_old = pick_src(q.s3, q.ctrl[CTL_SRC_HI:CTL_SRC_LO]);
    // Unsynchronised mode uses the same second-stage rising-edge detect; both cost two cycles
    tick = q.ctrl[CTL_RESYNC] ? (src_now && !src_old) : (src_now && !src_old);
    case (q.ctrl[CTL_PS_HI:CTL_PS_LO])
      PS_DIV64: ps_tc = PS_TC64;
      PS_DIV16: ps_tc = PS_TC16;
      PS_DIV4:  ps_tc = PS_TC4;
      default:  ps_tc = PS_TC1;
    endcase
    wide_tb  = q.ctrl[CTL_WIDE] ? q.tb  : {16'h0000, q.tb[15:0]};
    wide_per = q.ctrl[CTL_WIDE] ? q.per : {16'h0000, q.per[15:0]};
    // Time base with period rollover
    if (run && tick)
    begin
      if (q.ps >= ps_tc)
      begin
        d.ps = 6'h00;
        // Rollover in 16-bit mode clears only the low half; upper stays frozen
        if (wide_tb >= wide_per && q.ctrl[CTL_WIDE])
          d.tb = 32'h0000_0000;
        else if (wide_tb >= wide_per)
          d.tb[15:0] = 16'h0000;
        else if (q.ctrl[CTL_WIDE])
          d.tb = q.tb + 32'h0000_0001;
        else
          d.tb = {q.tb[31:16], q.tb[15:0] + 16'h0001};
      end
      else
        d.ps = q.ps + 6'h01;
    end
    else if (!q.ctrl[CTL_ENABLE])
      d.ps = 6'h00;
    // Compare matches, only on the compare path
    d.pri_hit = run && !q.ctrl[CTL_CAPSEL] && (wide_tb[15:0] == q.pri);
    d.sec_hit = run && !q.ctrl[CTL_CAPSEL] && (wide_tb[15:0] == q.sec);
    // Capture edge qualification by function field
    rise   = q.cap2 && !q.cap3;
    fall   = !q.cap2 && q.cap3;
    cap_ev = 1'b0;
    if (run && q.ctrl[CTL_CAPSEL])
    begin
      case (q.ctrl[CTL_FN_HI:CTL_FN_LO])
        CAP_BOTH_ED, CAP_BOTH: cap_ev = rise || fall;
        CAP_RISE:              cap_ev = rise;
        CAP_FALL:              cap_ev = fall;
        CAP_RISE4:
        begin
          if (rise) d.edges = (q.edges >= EDGE_TC4) ? 4'h0 : q.edges + 4'h1;
          cap_ev = rise && (q.edges >= EDGE_TC4);
        end
        CAP_RISE16:
        begin
          if (rise) d.edges = (q.edges == EDGE_TC16) ? 4'h0 : q.edges + 4'h1;
          cap_ev = rise && (q.edges == EDGE_TC16);
        end
        default:               cap_ev = 1'b0;
      endcase
    end
    // FIFO push; a full FIFO drops the capture and marks overflow
    wr_ptr = q.rd_ptr + q.cnt[1:0];
    if (cap_ev)
    begin
      if (q.cnt == 3'(CAP_DEPTH))
        d.ovf = 1'b1;
      else
      begin
        d.fifo[wr_ptr*32 +: 32] = wide_tb;
        d.cnt = q.cnt + 3'h1;
      end
    end
    // Bus address phase
    if (req)
    begin
      d.phase = ccptb_data;
      d.idx   = haddr[13:2];
      d.wr    = hwrite;
    end
    else
      d.phase = ccptb_idle;
    // Read data registered at the address phase
    d.rdata = 32'h0000_0000;
    if (req && !hwrite)
    begin
      if (haddr[13:2] == IDX_TB_LOWER)       d.rdata[15:0] = q.tb[15:0];
      else if (haddr[13:2] == IDX_TB_UPPER)  d.rdata[15:0] = q.tb[31:16];
      else if (haddr[13:2] == IDX_PER_LOWER) d.rdata[15:0] = q.per[15:0];
      else if (haddr[13:2] == IDX_PER_UPPER) d.rdata[15:0] = q.per[31:16];
      else if (haddr[13:2] == IDX_PRI_CMP)   d.rdata[15:0] = q.pri;
      else if (haddr[13:2] == IDX_SEC_CMP)   d.rdata[15:0] = q.sec;
      else if (haddr[13:2] == IDX_CTRL_LOW)  d.rdata[15:0] = q.ctrl;
      else if (haddr[13:2] == IDX_CAP_LOWER)
        d.rdata[15:0] = q.fifo[q.rd_ptr*32 +: 16];
      else if (haddr[13:2] == IDX_CAP_UPPER)
        d.rdata[15:0] = q.fifo[q.rd_ptr*32 + 16 +: 16];
      else if (haddr[13:2] == IDX_STATUS)
        d.rdata[15:0] = {14'h0000, q.ovf, q.cnt != 3'h0};
      // Reading the upper capture half pops the entry
      if (haddr[13:2] == IDX_CAP_UPPER && q.cnt != 3'h0)
      begin
        d.rd_ptr = q.rd_ptr + 2'h1;
        d.cnt    = d.cnt - 3'h1;
      end
    end
    // Write in the data phase
    if (q.phase == ccptb_data && q.wr)
    begin
      if (q.idx == IDX_TB_LOWER)       d.tb[15:0]  = wv[15:0];
      else if (q.idx == IDX_TB_UPPER)  d.tb[31:16] = wv[15:0];
      else if (q.idx == IDX_PER_LOWER) d.per[15:0]  = wv[15:0];
      else if (q.idx == IDX_PER_UPPER) d.per[31:16] = wv[15:0];
      else if (q.idx == IDX_PRI_CMP)   d.pri = wv[15:0];
      else if (q.idx == IDX_SEC_CMP)   d.sec = wv[15:0];
      else if (q.idx == IDX_CTRL_LOW)  d.ctrl = wv[15:0] & 16'hBFFF;
      // Overflow clears on status write of zero; a fresh overflow wins
      else if (q.idx == IDX_STATUS && !wv[STAT_OVF] && !(cap_ev && q.cnt == 3'(CAP_DEPTH)))
        d.ovf = 1'b0;
    end
    d.avail = (d.cnt != 3'h0);
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q <= '0;
    else
      q <= d;
  end

  // Upper count half reads back what was written, zero after reset
  tb_upper_rw_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (req && hwrite && haddr[13:2] == IDX_TB_UPPER) ##1 !(run && tick)
      |=> q.tb[31:16] == $past(hwdata[15:0])) else $error("upper count not written");
  per_lower_rw_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.phase == ccptb_data && q.wr && q.idx == IDX_PER_LOWER)
      |=> q.per[15:0] == $past(hwdata[15:0])) else $error("period low not written");
  per_upper_rw_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.phase == ccptb_data && q.wr && q.idx == IDX_PER_UPPER)
      |=> q.per[31:16] == $past(hwdata[15:0])) else $error("period high not written");
  pri_match_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (run && !q.ctrl[CTL_CAPSEL] && wide_tb[15:0] == q.pri) |=> primary_match)
    else $error("primary match missed");
  sec_match_a: assert property (@(posedge hclk) disable iff (!hresetn)
    secondary_match |-> $past(wide_tb[15:0] == q.sec && !q.ctrl[CTL_CAPSEL]))
    else $error("secondary match false");
  cap_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (req && !hwrite && haddr[13:2] == IDX_CAP_LOWER)
      |=> hrdata[15:0] == $past(q.fifo[q.rd_ptr*32 +: 16])) else $error("capture low wrong");
  disabled_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!q.ctrl[CTL_ENABLE] && !(q.phase == ccptb_data && q.wr)) |=> $stable(q.tb))
    else $error("count moved while disabled");
  idle_halt_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (power_state.idle && q.ctrl[CTL_HALT_IDLE]) |-> !run) else $error("ran in idle");
  sleep_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (power_state.sleep && !q.ctrl[CTL_RUN_SLEEP]) |-> !run) else $error("ran in sleep");
  narrow_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!q.ctrl[CTL_WIDE] && !(q.phase == ccptb_data && q.wr)) |=> $stable(q.tb[31:16]))
    else $error("upper half moved in 16-bit mode");
  avail_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
    capture_data_available == (q.cnt != 3'h0)) else $error("available flag wrong");

endmodule // ccptb_top

// ==== dv/ccptb_src_model.sv ====
// Far-side model: count source pins and capture pin
`timescale 1ns/1ps
module ccptb_src_model
  import ccptb_pkg::*;
(
  // Clock and requests from the bench
  input  wire logic             hclk,
  input  wire logic             go,
  input  wire logic [2:0]       sel,
  input  wire logic [15:0]      n_edges,
  input  wire logic             cap_go,
  // Far-side pins and status
  output ccptb_pkg::ccptb_src_t count_sources,
  output logic                  capture_in,
  output logic                  busy
);
  logic [7:0] src;  // Source levels, bit index equals select code

  assign count_sources = ccptb_src_t'(src);
  // Sources stand still low between bursts, as a stopped clock
  initial
  begin
    src = 8'h00;
    capture_in = 1'b0;
    busy = 1'b0;
  end
  // Exact burst of slow edges on the chosen source only
  always @(posedge go)
  begin
    busy <= 1'b1;
    repeat (n_edges)
    begin
      repeat (3) @(posedge hclk);
      src[sel] <= 1'b1;
      repeat (3) @(posedge hclk);
      src[sel] <= 1'b0;
    end
    repeat (3) @(posedge hclk);
    busy <= 1'b0;
  end
  // One wide pulse, long enough for the pin synchroniser
  always @(posedge cap_go)
  begin
    repeat (2) @(posedge hclk);
    capture_in <= 1'b1;
    repeat (6) @(posedge hclk);
    capture_in <= 1'b0;
  end
endmodule // ccptb_src_model

// ==== dv/tb_top.sv ====
// Self-checking bench of the time base, compare and capture unit
`timescale 1ns/1ps
module tb_top;
  import ccptb_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, go = 0, cap_go = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, v;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2, sel = '0;
  logic [15:0] n_edges = '0, rnd = 16'h001D;  // Random state starts at 29
  logic hreadyout, hresp, pm, sm, avail, busy, capture_in;
  ccptb_src_t srcs;
  ccptb_pwr_t pwr = '0;
  int err_count = 0, n_compared = 0;
  logic [31:0] capq[$];  // Reference capture FIFO
  logic [15:0] ctl_t[5] = '{16'h0000, 16'hA000, 16'h8000, 16'h8000, 16'h9000};
  logic [1:0] pwr_t[5] = '{2'h0, 2'h2, 2'h2, 2'h1, 2'h1};
  int exp_t[5] = '{0, 0, 8, 0, 8};

  // 40 ns clock
  always #20 hclk = ~hclk;

  ccptb_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .count_sources(srcs), .capture_in(capture_in), .power_state(pwr),
    .primary_match(pm), .secondary_match(sm), .capture_data_available(avail));
  ccptb_src_model far (.hclk(hclk), .go(go), .sel(sel), .n_edges(n_edges),
    .cap_go(cap_go), .count_sources(srcs), .capture_in(capture_in), .busy(busy));

  // Next random value
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Control word from its fields
  function automatic logic [31:0] ctl(input logic en, input logic [2:0] s,
    input logic [1:0] ps, input logic wd, input logic cs, input logic [3:0] fn);
    return (32'(en) << CTL_ENABLE) | (32'(s) << CTL_SRC_LO) | (32'(ps) << CTL_PS_LO)
      | (32'(wd) << CTL_WIDE) | (32'(cs) << CTL_CAPSEL) | 32'(fn);
  endfunction
  // One single word transfer; the bus never waits, but we still poll ready
  task automatic bus(input logic [11:0] idx, input logic w, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {18'h0, idx, 2'b00}; htrans <= HTRANS_NSEQ; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hsel <= 1'b0; hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] t;
    bus(idx, 1'b1, d, t);
  endtask
  // Register read compare
  task automatic chk_reg(input string nm, input logic [11:0] idx, input logic [31:0] e);
    logic [31:0] g;
    bus(idx, 1'b0, 32'h0, g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Output pin compare
  task automatic chk_pin(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  // Clear the count, then let the far side give n edges on source s
  task automatic run(input logic [2:0] s, input int n);
    wr(IDX_TB_LOWER, 32'h0);
    wr(IDX_TB_UPPER, 32'h0);
    @(posedge hclk);
    sel <= s; n_edges <= 16'(n); go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    for (int i = 0; i < 20000 && busy !== 1'b0; i++) @(posedge hclk);
    repeat (6) @(posedge hclk);
  endtask
  task automatic capture();
    @(posedge hclk);
    cap_go <= 1'b1;
    @(posedge hclk);
    cap_go <= 1'b0;
    repeat (16) @(posedge hclk);
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog, well beyond the expected run
  initial
  begin
    #2000000;
    err_count++;
    results();
  end
  // Main sequence
  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values
    chk_reg("tb_upper", IDX_TB_UPPER, 32'h0);
    chk_reg("per_lower", IDX_PER_LOWER, 32'h0);
    chk_reg("per_upper", IDX_PER_UPPER, 32'h0);
    chk_reg("pri", IDX_PRI_CMP, 32'h0);
    chk_reg("sec", IDX_SEC_CMP, 32'h0);
    chk_reg("ctrl", IDX_CTRL_LOW, 32'h0);
    chk_reg("cap_lower", IDX_CAP_LOWER, 32'h0);
    chk_reg("cap_upper", IDX_CAP_UPPER, 32'h0);
    chk_pin("avail", 1'b0, avail);
    // Random read back, sources idle so nothing counts
    foreach (ctl_t[i])
    begin
      rnd = lfsr(rnd);
      wr(IDX_TB_UPPER + 12'(i), {16'h0, rnd});
    end
    rnd = 16'h001D;
    rnd = lfsr(rnd);
    chk_reg("tb_upper", IDX_TB_UPPER, {16'h0, rnd});
    for (int k = 0; k < 4; k++)
    begin
      rnd = lfsr(rnd);
      v = (k == 3) ? {20'h0, IDX_SEC_CMP} : {20'h0, IDX_PER_LOWER + 12'(2 * k)};
      wr(v[11:0], {16'h0, rnd});
      chk_reg("rw", v[11:0], {16'h0, rnd});
    end
    wr(IDX_CTRL_LOW, 32'h0000_4A5A);
    chk_reg("ctrl", IDX_CTRL_LOW, 32'h0000_0A5A);
    wr(12'h2B0, 32'h0000_1234);
    chk_reg("unmapped", 12'h2B0, 32'h0);
    chk_pin("hresp", 1'b0, hresp);
    // Free period so no rollover in the 32-bit runs below
    wr(IDX_PER_LOWER, 32'h0000_FFFF);
    wr(IDX_PER_UPPER, 32'h0000_FFFF);
    // Every prescale ratio
    for (int p = 0; p < 4; p++)
    begin
      wr(IDX_CTRL_LOW, ctl(1'b1, SRC_EXT_A, 2'(p), 1'b1, 1'b0, 4'h0));
      run(SRC_EXT_A, 128);
      chk_reg("tb_lower", IDX_TB_LOWER, 32'(128 >> (2 * p)));
    end
    // Every source code, resync bit set
    for (int s = 0; s < 8; s++)
    begin
      wr(IDX_CTRL_LOW, ctl(1'b1, 3'(s), 2'h0, 1'b1, 1'b0, 4'h0) | 32'h0800);
      run(3'(s), 8);
      chk_reg("tb_lower", IDX_TB_LOWER, 32'h8);
      run(3'(s + 1), 8);
      chk_reg("tb_lower", IDX_TB_LOWER, 32'h0);
    end
    // Enable, idle and sleep table
    foreach (ctl_t[i])
    begin
      pwr <= ccptb_pwr_t'(pwr_t[i]);
      wr(IDX_CTRL_LOW, 32'(ctl_t[i]) | 32'h0020);
      run(SRC_PCLK, 8);
      chk_reg("tb_lower", IDX_TB_LOWER, 32'(exp_t[i]));
    end
    pwr <= '0;
    // Compare matches
    wr(IDX_PRI_CMP, 32'h5);
    wr(IDX_SEC_CMP, 32'h9);
    wr(IDX_CTRL_LOW, ctl(1'b1, SRC_PCLK, 2'h0, 1'b1, 1'b0, 4'h0));
    run(SRC_PCLK, 5);
    chk_pin("primary_match", 1'b1, pm);
    chk_pin("secondary_match", 1'b0, sm);
    run(SRC_PCLK, 9);
    chk_pin("primary_match", 1'b0, pm);
    chk_pin("secondary_match", 1'b1, sm);
    // Narrow and wide count at the half boundary
    for (int w = 0; w < 2; w++)
    begin
      wr(IDX_PER_UPPER, 32'h0000_FFFF);
      wr(IDX_CTRL_LOW, ctl(1'b1, SRC_PCLK, 2'h0, 1'(w), 1'b0, 4'h0));
      wr(IDX_TB_LOWER, 32'h0000_FFFF);
      @(posedge hclk);
      sel <= SRC_PCLK; n_edges <= 16'h1; go <= 1'b1;
      @(posedge hclk);
      go <= 1'b0;
      for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge hclk);
      repeat (6) @(posedge hclk);
      chk_reg("tb_upper", IDX_TB_UPPER, 32'(w));
    end
    // Compare path ignores the capture pin
    wr(IDX_CTRL_LOW, ctl(1'b1, SRC_PCLK, 2'h0, 1'b1, 1'b0, CAP_RISE));
    capture();
    chk_pin("avail", 1'b0, avail);
    // Two captures then drain in order
    wr(IDX_CTRL_LOW, ctl(1'b1, SRC_PCLK, 2'h0, 1'b1, 1'b1, CAP_RISE));
    for (int k = 1; k < 3; k++)
    begin
      rnd = lfsr(rnd);
      wr(IDX_TB_LOWER, {16'h0, rnd});
      wr(IDX_TB_UPPER, 32'(k));
      capq.push_back({16'(k), rnd});
      capture();
    end
    chk_pin("avail", 1'b1, avail);
    chk_reg("status", IDX_STATUS, 32'h1);
    while (capq.size() > 0)
    begin
      v = capq.pop_front();
      chk_reg("cap_lower", IDX_CAP_LOWER, {16'h0, v[15:0]});
      chk_reg("cap_upper", IDX_CAP_UPPER, {16'h0, v[31:16]});
    end
    repeat (2) @(posedge hclk);
    chk_pin("avail", 1'b0, avail);
    results();
  end
endmodule // tb_top
